/* sbfe_pkg.sv */
// Shared constants and types for the slot B front end configuration bank
`default_nettype none
package sbfe_pkg;
    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_PULSE_POLARITY_ORDER = 8'h1d;
    localparam logic [7:0] IDX_INTEGRATION_WINDOW = 8'h3b;
    localparam logic [7:0] IDX_AMPLIFIER_CONTROL = 8'h44;
    localparam int REG_W = 16;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = 4;
    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int ORDER_LSB = 0;
    localparam int ORDER_MSB = 3;
    localparam int WIDTH_LSB = 11;
    localparam int WIDTH_MSB = 15;
    localparam int OFFSET_LSB = 0;
    localparam int OFFSET_MSB = 10;
    localparam int MODE_LSB = 10;
    localparam int MODE_MSB = 15;
    localparam int BUF_GAIN_BIT = 9;
    localparam int BUF_EN_BIT = 7;
    localparam int IND_EN_BIT = 6;
    localparam int VREF_LSB = 4;
    localparam int VREF_MSB = 5;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_MSB = 1;
    localparam int PULSES_PER_GROUP = 4;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_PULSE_POLARITY_ORDER = 16'h0000;
    localparam logic [15:0] RST_INTEGRATION_WINDOW = 16'h2017;
    localparam logic [15:0] RST_AMPLIFIER_CONTROL = 16'h1c38;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int WIDTH_STEP_NS = 1000;
    localparam int WIDTH_STEP_CYCLES = WIDTH_STEP_NS / CLOCK_PERIOD_NS;
    localparam int WIDTH_CYCLES_W = 12;
    // ----------------------------------------------------------------
    // Bus answers and decode
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_ORDER,
        SEL_WINDOW,
        SEL_AMP
    } sbfe_sel_type;
endpackage
`default_nettype wire

/* sbfe_pulse_seq.sv */
// Per-pulse integration polarity sequencer over a four-pulse group
`timescale 1ns/10ps
`default_nettype none
module sbfe_pulse_seq
    import sbfe_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic slot_start,
    input wire logic pulse_done,
    input wire logic [ORDER_MSB:ORDER_LSB] order,
    output logic reverse,
    output logic [1:0] pulse_number
);
    localparam logic [1:0] LAST_PULSE = 2'(PULSES_PER_GROUP - 1);

    logic [1:0] next_pulse_number;

    always_comb begin
        next_pulse_number = pulse_number;
        if (slot_start) begin
            next_pulse_number = 2'h0;
        end else if (pulse_done) begin
            if (pulse_number == LAST_PULSE) begin
                next_pulse_number = 2'h0;
            end else begin
                next_pulse_number = pulse_number + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pulse_number <= 2'h0;
        end else begin
            pulse_number <= next_pulse_number;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reverse <= 1'b0;
        end else begin
            reverse <= order[next_pulse_number];
        end
    end
endmodule
`default_nettype wire

/* sbfe_config_regs.sv */
// Slot B front end configuration registers behind an AXI4-Lite slave
// Contract
// - Order bit n sets pulse n+1 polarity
// - After four pulses restart at bit 0
// - Width bits 15:11, 1 us steps, default 4
// - Window offset bits 10:0, 31.25 ns steps
// - Bit 9 picks buffer gain 1 or 0.7
// - Bit 7 turns integrator into buffer
// - Bit 6 enables individual channel gains
// - Bits 5:4 select amplifier reference, default 3
// - Bits 1:0 gain for channel one or all
// - Gain codes 2 and 3 are 50k, 25k
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module sbfe_config_regs
    import sbfe_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [AXI_DATA_W-1:0] S_AXI_WDATA,
    input wire logic [AXI_STRB_W-1:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [AXI_DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic SLOT_START,
    input wire logic PULSE_DONE,
    input wire logic [5:0] CH234_GAIN,
    output logic PULSE_REVERSE,
    output logic [1:0] PULSE_NUMBER,
    output logic [WIDTH_MSB-WIDTH_LSB:0] WINDOW_WIDTH,
    output logic [WIDTH_CYCLES_W-1:0] WINDOW_WIDTH_CYCLES,
    output logic [OFFSET_MSB-OFFSET_LSB:0] WINDOW_OFFSET,
    output logic [MODE_MSB-MODE_LSB:0] FRONTEND_MODE,
    output logic BUFFER_GAIN_SELECT,
    output logic INTEGRATOR_BUFFER_ENABLE,
    output logic PER_CHANNEL_GAIN_ENABLE,
    output logic [1:0] AMP_REFERENCE_SELECT,
    output logic [7:0] CH_GAIN
);
    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic sbfe_sel_type decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-3:0] word;
        word = addr[ADDR_W-1:2];
        if (word == (ADDR_W-2)'(IDX_PULSE_POLARITY_ORDER)) begin
            decode = SEL_ORDER;
        end else if (word == (ADDR_W-2)'(IDX_INTEGRATION_WINDOW)) begin
            decode = SEL_WINDOW;
        end else if (word == (ADDR_W-2)'(IDX_AMPLIFIER_CONTROL)) begin
            decode = SEL_AMP;
        end else begin
            decode = SEL_NONE;
        end
    endfunction

    function automatic logic [REG_W-1:0] merge(
        input logic [REG_W-1:0] old,
        input logic [AXI_DATA_W-1:0] data,
        input logic [AXI_STRB_W-1:0] strb
    );
        logic [REG_W-1:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        merge = res;
    endfunction

    function automatic logic [WIDTH_CYCLES_W-1:0] width_cycles(
        input logic [WIDTH_MSB-WIDTH_LSB:0] width
    );
        width_cycles = WIDTH_CYCLES_W'(width * WIDTH_STEP_CYCLES);
    endfunction

    // ----------------------------------------------------------------
    // Storage and bus state
    // ----------------------------------------------------------------
    logic [REG_W-1:0] pulse_polarity_order;
    logic [REG_W-1:0] integration_window;
    logic [REG_W-1:0] amplifier_control;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [AXI_DATA_W-1:0] w_data;
    logic [AXI_STRB_W-1:0] w_strb;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    logic next_rvalid;
    sbfe_sel_type wr_sel;
    sbfe_sel_type rd_sel;
    localparam logic [WIDTH_CYCLES_W-1:0] RST_WIDTH_CYCLES =
        WIDTH_CYCLES_W'(RST_INTEGRATION_WINDOW[WIDTH_MSB:WIDTH_LSB] * WIDTH_STEP_CYCLES);

    // ----------------------------------------------------------------
    // Write channel handshakes
    // ----------------------------------------------------------------
    always_comb begin
        aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
        w_hs = S_AXI_WVALID & S_AXI_WREADY;
        ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
        // Address and data may arrive in either order
        do_write = aw_held & w_held & ~S_AXI_BVALID;
        next_aw_held = (aw_held & ~do_write) | aw_hs;
        next_w_held = (w_held & ~do_write) | w_hs;
        next_bvalid = do_write | (S_AXI_BVALID & ~S_AXI_BREADY);
        next_rvalid = ar_hs | (S_AXI_RVALID & ~S_AXI_RREADY);
        wr_sel = decode(aw_addr);
        rd_sel = decode(S_AXI_ARADDR);
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            aw_addr <= '0;
        end else if (aw_hs) begin
            aw_addr <= S_AXI_AWADDR;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            w_data <= '0;
            w_strb <= '0;
        end else if (w_hs) begin
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b1;
        end else begin
            S_AXI_AWREADY <= ~next_aw_held & ~next_bvalid;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_WREADY <= 1'b1;
        end else begin
            S_AXI_WREADY <= ~next_w_held & ~next_bvalid;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else begin
            S_AXI_BVALID <= next_bvalid;
            if (do_write) begin
                S_AXI_BRESP <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pulse_polarity_order <= RST_PULSE_POLARITY_ORDER;
        end else if (do_write && wr_sel == SEL_ORDER) begin
            pulse_polarity_order <= merge(pulse_polarity_order, w_data, w_strb);
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            integration_window <= RST_INTEGRATION_WINDOW;
        end else if (do_write && wr_sel == SEL_WINDOW) begin
            integration_window <= merge(integration_window, w_data, w_strb);
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            amplifier_control <= RST_AMPLIFIER_CONTROL;
        end else if (do_write && wr_sel == SEL_AMP) begin
            amplifier_control <= merge(amplifier_control, w_data, w_strb);
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
        end else begin
            S_AXI_ARREADY <= ~next_rvalid;
            S_AXI_RVALID <= next_rvalid;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (ar_hs) begin
            S_AXI_RRESP <= RESP_OKAY;
            case (rd_sel)
                SEL_ORDER: begin
                    S_AXI_RDATA <= AXI_DATA_W'(pulse_polarity_order);
                end
                SEL_WINDOW: begin
                    S_AXI_RDATA <= AXI_DATA_W'(integration_window);
                end
                SEL_AMP: begin
                    S_AXI_RDATA <= AXI_DATA_W'(amplifier_control);
                end
                default: begin
                    S_AXI_RDATA <= '0;
                    S_AXI_RRESP <= RESP_SLVERR;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Integration window outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            WINDOW_WIDTH <= RST_INTEGRATION_WINDOW[WIDTH_MSB:WIDTH_LSB];
        end else begin
            WINDOW_WIDTH <= integration_window[WIDTH_MSB:WIDTH_LSB];
        end
    end

    // Width in clock cycles for the window timer
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            WINDOW_WIDTH_CYCLES <= RST_WIDTH_CYCLES;
        end else begin
            WINDOW_WIDTH_CYCLES <= width_cycles(integration_window[WIDTH_MSB:WIDTH_LSB]);
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            WINDOW_OFFSET <= RST_INTEGRATION_WINDOW[OFFSET_MSB:OFFSET_LSB];
        end else begin
            WINDOW_OFFSET <= integration_window[OFFSET_MSB:OFFSET_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Amplifier and integrator controls
    // ----------------------------------------------------------------
    // Mode field passes through; software keeps it at its set value
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            FRONTEND_MODE <= RST_AMPLIFIER_CONTROL[MODE_MSB:MODE_LSB];
        end else begin
            FRONTEND_MODE <= amplifier_control[MODE_MSB:MODE_LSB];
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            BUFFER_GAIN_SELECT <= RST_AMPLIFIER_CONTROL[BUF_GAIN_BIT];
        end else begin
            BUFFER_GAIN_SELECT <= amplifier_control[BUF_GAIN_BIT];
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            INTEGRATOR_BUFFER_ENABLE <= RST_AMPLIFIER_CONTROL[BUF_EN_BIT];
        end else begin
            INTEGRATOR_BUFFER_ENABLE <= amplifier_control[BUF_EN_BIT];
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PER_CHANNEL_GAIN_ENABLE <= RST_AMPLIFIER_CONTROL[IND_EN_BIT];
        end else begin
            PER_CHANNEL_GAIN_ENABLE <= amplifier_control[IND_EN_BIT];
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            AMP_REFERENCE_SELECT <= RST_AMPLIFIER_CONTROL[VREF_MSB:VREF_LSB];
        end else begin
            AMP_REFERENCE_SELECT <= amplifier_control[VREF_MSB:VREF_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Channel gain codes: 0 200k, 1 100k, 2 50k, 3 25k
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            CH_GAIN <= {4{RST_AMPLIFIER_CONTROL[GAIN_MSB:GAIN_LSB]}};
        end else if (amplifier_control[IND_EN_BIT]) begin
            CH_GAIN <= {CH234_GAIN, amplifier_control[GAIN_MSB:GAIN_LSB]};
        end else begin
            CH_GAIN <= {4{amplifier_control[GAIN_MSB:GAIN_LSB]}};
        end
    end

    // ----------------------------------------------------------------
    // Pulse polarity sequencing
    // ----------------------------------------------------------------
    sbfe_pulse_seq u_pulse_seq (
        .clock(CLOCK),
        .rst(RST),
        .slot_start(SLOT_START),
        .pulse_done(PULSE_DONE),
        .order(pulse_polarity_order[ORDER_MSB:ORDER_LSB]),
        .reverse(PULSE_REVERSE),
        .pulse_number(PULSE_NUMBER)
    );
endmodule
`default_nettype wire

/* sbfe_config_regs_properties.sv */
// Port-level checks of the slot B front end configuration bank
`timescale 1ns/10ps
`default_nettype none
module sbfe_config_regs_properties
    import sbfe_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic SLOT_START,
    input wire logic PULSE_DONE,
    input wire logic [1:0] PULSE_NUMBER,
    input wire logic [WIDTH_MSB-WIDTH_LSB:0] WINDOW_WIDTH,
    input wire logic [WIDTH_CYCLES_W-1:0] WINDOW_WIDTH_CYCLES,
    input wire logic PER_CHANNEL_GAIN_ENABLE,
    input wire logic [5:0] CH234_GAIN,
    input wire logic [7:0] CH_GAIN
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    property p_width_cycles; WINDOW_WIDTH_CYCLES == WINDOW_WIDTH * 12'h064;
    endproperty
    a_width_cycles: assert property (p_width_cycles) else $error("width cycles");
    property p_gain_own; PER_CHANNEL_GAIN_ENABLE && $past(PER_CHANNEL_GAIN_ENABLE)
        |-> CH_GAIN[7:2] == $past(CH234_GAIN);
    endproperty
    a_gain_own: assert property (p_gain_own) else $error("own gains");
    property p_gain_shared; !PER_CHANNEL_GAIN_ENABLE && !$past(PER_CHANNEL_GAIN_ENABLE)
        |-> CH_GAIN == {4{CH_GAIN[1:0]}};
    endproperty
    a_gain_shared: assert property (p_gain_shared) else $error("shared gain");
    property p_advance; PULSE_DONE && !SLOT_START |=> PULSE_NUMBER == $past(PULSE_NUMBER) + 2'h1;
    endproperty
    a_advance: assert property (p_advance) else $error("pulse advance");
    property p_restart; SLOT_START |=> PULSE_NUMBER == 2'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("group restart");
    property p_hold; !PULSE_DONE && !SLOT_START |=> $stable(PULSE_NUMBER);
    endproperty
    a_hold: assert property (p_hold) else $error("pulse hold");
    property p_wr_answer; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer");
    property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer");
endmodule
bind sbfe_config_regs sbfe_config_regs_properties u_props (.CLOCK(CLOCK), .RST(RST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .SLOT_START(SLOT_START),
    .PULSE_DONE(PULSE_DONE), .PULSE_NUMBER(PULSE_NUMBER), .WINDOW_WIDTH(WINDOW_WIDTH),
    .WINDOW_WIDTH_CYCLES(WINDOW_WIDTH_CYCLES), .CH234_GAIN(CH234_GAIN), .CH_GAIN(CH_GAIN),
    .PER_CHANNEL_GAIN_ENABLE(PER_CHANNEL_GAIN_ENABLE));
`default_nettype wire

/* sbfe_config_regs_tb.sv */
// Self-checking bench of the slot B front end configuration bank
`timescale 1ns/10ps
`default_nettype none
module sbfe_config_regs_tb
    import sbfe_pkg::*;
;
    logic clock = 1'b0;
    logic rst, awv, wv, br, arv, rr, ss, pd, awr, wr, bv, arr, rv, rev, bg, ib, ie;
    logic [11:0] awa, ara, wcyc;
    logic [31:0] wd, rd;
    logic [3:0] ws;
    logic [1:0] bre, rre, pn, vr;
    logic [5:0] c234, mode;
    logic [4:0] wid;
    logic [10:0] ofs;
    logic [7:0] chg;
    int n_errors = 0, checks_done = 0, cycles = 0;
    initial forever #5 clock = ~clock;
    sbfe_config_regs #(.ADDR_W(12)) uut (.CLOCK(clock), .RST(rst),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bre),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rre), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .SLOT_START(ss), .PULSE_DONE(pd), .CH234_GAIN(c234),
        .PULSE_REVERSE(rev), .PULSE_NUMBER(pn), .WINDOW_WIDTH(wid), .WINDOW_WIDTH_CYCLES(wcyc),
        .WINDOW_OFFSET(ofs), .FRONTEND_MODE(mode), .BUFFER_GAIN_SELECT(bg),
        .INTEGRATOR_BUFFER_ENABLE(ib), .PER_CHANNEL_GAIN_ENABLE(ie),
        .AMP_REFERENCE_SELECT(vr), .CH_GAIN(chg));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("mismatches %0d, comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        logic aw_ok = 1'b0, w_ok = 1'b0;
        @(posedge clock);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (!aw_ok && awr) begin
                aw_ok = 1'b1;
                awv <= 1'b0;
            end
            if (!w_ok && wr) begin
                w_ok = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clock); while (!bv);
        br <= 1'b0;
        check(32'(bre), 32'(er));
    endtask
    task automatic bus_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clock);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clock); while (!arr);
        arv <= 1'b0;
        do @(posedge clock); while (!rv);
        rr <= 1'b0;
        check(rd, ed);
        check(32'(rre), 32'(er));
    endtask
    task automatic t_reset;
        bus_rd(12'h074, 32'h0, RESP_OKAY);
        bus_rd(12'h0ec, 32'h2017, RESP_OKAY);
        bus_rd(12'h110, 32'h1c38, RESP_OKAY);
        check(32'({wid, wcyc, ofs}), {4'h0, 5'h4, 12'h190, 11'h17});
        check(32'({mode, vr, bg, ib, ie, pn, chg}), 32'({6'h07, 2'h3, 13'h0}));
    endtask
    task automatic t_window;
        logic [15:0] v [3] = '{16'hf801, 16'h8800, 16'h07ff};
        foreach (v[i]) begin
            bus_wr(12'h0ec, {16'h0, v[i]}, 4'h3, RESP_OKAY);
            bus_rd(12'h0ec, {16'h0, v[i]}, RESP_OKAY);
            check(32'({wid, wcyc, ofs}), 32'({v[i][15:11], 12'(v[i][15:11] * 12'h064),
                v[i][10:0]}));
        end
    endtask
    task automatic t_amp;
        logic [1:0] c;
        logic [15:0] d;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            d = {6'h07, c[0], 1'b0, c[1], ^c, c, 2'h1, c};
            c234 <= 6'h2d ^ 6'(i);
            bus_wr(12'h110, {16'h0, d}, 4'h3, RESP_OKAY);
            bus_rd(12'h110, {16'h0, d}, RESP_OKAY);
            check(32'({mode, bg, ib, ie, vr}), 32'({6'h07, c[0], c[1], ^c, c}));
            check(32'(chg), ^c ? 32'({6'h2d ^ 6'(i), c}) : 32'({4{c}}));
        end
    endtask
    task automatic t_pulse;
        logic [3:0] ord;
        for (int k = 0; k < 2; k++) begin
            ord = k ? 4'ha : 4'h5;
            bus_wr(12'h074, {28'h0, ord}, 4'h1, RESP_OKAY);
            @(posedge clock);
            #1;
            check(32'(rev), 32'(ord[2 * k]));
            @(posedge clock);
            ss <= 1'b1;
            pd <= 1'b1;
            @(posedge clock);
            ss <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                #1;
                check(32'({pn, rev}), 32'({2'(i), ord[i % 4]}));
                @(posedge clock);
            end
            pd <= 1'b0;
            @(posedge clock);
            #1;
            check(32'(pn), 32'h2);
        end
    endtask
    task automatic t_errors;
        bus_wr(12'h114, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        bus_rd(12'h000, 32'h0, RESP_SLVERR);
        bus_wr(12'h0ec, 32'habcd_1234, 4'hd, RESP_OKAY);
        bus_rd(12'h0ec, 32'h0734, RESP_OKAY);
        bus_rd(12'h110, 32'h1eb7, RESP_OKAY);
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        rst = 1'b1;
        {awv, wv, br, arv, rr, ss, pd} = 7'h0;
        {awa, ara, wd, ws} = 60'h0;
        c234 = 6'h2d;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_window();
        t_amp();
        t_pulse();
        t_errors();
        end_of_test();
    end
endmodule
`default_nettype wire
